// file: cbtc_pkg.sv
// Behaviour
// - Match primary opcode 0x13 and extended 0x210; slice options, index, link fields.
// - Index picks one condition bit; pass if options bit0, or bit equals options bit1.
// - Taken goes to count bits 0-29 with 00 appended; otherwise sequential.
// - Link flag set on a branch with options bit2 set writes current address plus four into link register.
// - Count-to-register form with options bit2 clear is an invalid form.
// - Options value 12 branches only when the selected condition bit is set.
// - Options value 4 branches only when the selected condition bit is clear.
// - Less-than flag of field n is condition bit 4n.
// - Greater-than flag of field n is condition bit 4n+1.
// - Equal flag of field n is condition bit 4n+2.
// - Bit 4n+3 is both summary-overflow and unordered flag of field n.
// - Conditional branch has relative, absolute, and both with link variants.
// - Absolute target is displacement with 00 appended, sign-extended, no add.
package cbtc_pkg;

  // ----------------------------------------
  // Instruction encoding
  // ----------------------------------------
  localparam logic [5:0] OPC_BCCTR = 6'h13;
  localparam logic [5:0] OPC_BC    = 6'h10;
  localparam logic [9:0] XO_BCCTR  = 10'h210;
  localparam int OPC_HI  = 31;
  localparam int OPC_LO  = 26;
  localparam int BO_HI   = 25;
  localparam int BO_LO   = 21;
  localparam int BI_HI   = 20;
  localparam int BI_LO   = 16;
  localparam int RSV_HI  = 15;
  localparam int RSV_LO  = 11;
  localparam int BD_HI   = 15;
  localparam int BD_LO   = 2;
  localparam int XO_HI   = 10;
  localparam int XO_LO   = 1;
  localparam int AA_BIT  = 1;
  localparam int LK_BIT  = 0;
  // Options bits, LSB-zero vector index inside the 5-bit field
  localparam int BO_ALWAYS = 4;
  localparam int BO_SENSE  = 3;
  localparam int BO_NODEC  = 2;
  localparam logic [4:0] BO_IF_TRUE  = 5'h0c;
  localparam logic [4:0] BO_IF_FALSE = 5'h04;
  // Flag position inside a condition field
  localparam logic [1:0] FLAG_LT = 2'h0;
  localparam logic [1:0] FLAG_GT = 2'h1;
  localparam logic [1:0] FLAG_EQ = 2'h2;
  localparam logic [1:0] FLAG_SO = 2'h3;
  localparam logic [4:0] MSB_POS    = 5'h1f;
  localparam logic [31:0] INSTR_BYTES = 32'h0000_0004;
  localparam logic [31:0] ADDR_RST    = 32'h0000_0000;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int OFS_W = 8;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CIA   = 8'h04;
  localparam logic [7:0] OFS_CTR   = 8'h08;
  localparam logic [7:0] OFS_CR    = 8'h0c;
  localparam logic [7:0] OFS_NIA   = 8'h10;
  localparam logic [7:0] OFS_LR    = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  // Status layout
  localparam int ST_TAKEN   = 0;
  localparam int ST_LINKED  = 1;
  localparam int ST_INVALID = 2;
  localparam int ST_UNSUPP  = 3;
  localparam int ST_RSVD    = 4;
  localparam int ST_ABS     = 5;
  localparam int ST_FLAG_LO = 6;
  localparam int ST_FIELD_LO = 8;
  localparam int ST_KIND_LO = 11;

  typedef enum logic [1:0] {
    KIND_OTHER = 2'b00,
    KIND_BCCTR = 2'b01,
    KIND_BC    = 2'b10,
    KIND_BAD   = 2'b11
  } cbtc_kind_e;

endpackage : cbtc_pkg

// file: cbtc_cond_eval.sv
`timescale 1ns/1ns
module cbtc_cond_eval (
  input  wire logic [31:0] conditionRegisterBits,
  input  wire logic [4:0]  condBitIndex,
  input  wire logic [4:0]  branchOptions,
  output logic             condBit,
  output logic             condOk,
  output logic [2:0]       condFieldSelect,
  output logic [1:0]       condFlag
);

  // ----------------------------------------
  // Field and flag split of the index
  // ----------------------------------------
  // Index is 4*field + flag, so low two bits name LT/GT/EQ/SO
  assign condFieldSelect = condBitIndex[4:2];
  assign condFlag        = condBitIndex[1:0];

  // Bit 0 is the MSB, so index is mirrored into the vector
  logic [4:0] bitPos;
  assign bitPos  = cbtc_pkg::MSB_POS - condBitIndex;
  assign condBit = conditionRegisterBits[bitPos];

  // Always-flag wins; else the bit must match the sense bit
  assign condOk = branchOptions[cbtc_pkg::BO_ALWAYS]
                | (condBit == branchOptions[cbtc_pkg::BO_SENSE]);

endmodule : cbtc_cond_eval

// file: cbtc_branch_unit.sv
`timescale 1ns/1ns
module cbtc_branch_unit (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic [cbtc_pkg::OFS_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic      [31:0]                nextInstrAddr,
  output logic      [31:0]                linkRegister,
  output logic                            branchTaken,
  output logic                            formInvalid
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] instrWord_reg;
  logic [31:0] currentInstrAddr_reg;
  logic [31:0] countReg_reg;
  logic [31:0] conditionRegisterBits_reg;
  logic [31:0] nextInstrAddr_reg;
  logic [31:0] linkRegister_reg;
  logic [15:0] status_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        branchTaken_reg;
  logic        formInvalid_reg;

  logic [31:0] nextInstrAddr_next;
  logic [31:0] linkRegister_next;
  logic [15:0] status_next;
  logic [31:0] prdata_next;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Setup samples read data so the access phase has no wait state
  logic setupPhase;
  logic accessDone;
  logic writeDone;
  logic hitInstr;
  logic hitCia;
  logic hitCtr;
  logic hitCr;
  logic hitNia;
  logic hitLr;
  logic hitStat;
  logic mapped;
  logic instrWrite;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & pready_reg;
  assign writeDone  = accessDone & pwrite;
  assign hitInstr   = (paddr == cbtc_pkg::OFS_INSTR);
  assign hitCia     = (paddr == cbtc_pkg::OFS_CIA);
  assign hitCtr     = (paddr == cbtc_pkg::OFS_CTR);
  assign hitCr      = (paddr == cbtc_pkg::OFS_CR);
  assign hitNia     = (paddr == cbtc_pkg::OFS_NIA);
  assign hitLr      = (paddr == cbtc_pkg::OFS_LR);
  assign hitStat    = (paddr == cbtc_pkg::OFS_STAT);
  assign mapped     = hitInstr | hitCia | hitCtr | hitCr | hitNia | hitLr | hitStat;
  assign instrWrite = writeDone & hitInstr;

  // ----------------------------------------
  // Instruction field slicing
  // ----------------------------------------
  // Fields come straight from the write data so the result lands at the same edge
  logic [5:0]  primaryOpcode;
  logic [9:0]  extendedOpcode;
  logic [4:0]  branchOptions;
  logic [4:0]  condBitIndex;
  logic [4:0]  reservedBits;
  logic [13:0] branchDisplacement;
  logic        absoluteFlag;
  logic        linkFlag;

  assign primaryOpcode      = pwdata[cbtc_pkg::OPC_HI:cbtc_pkg::OPC_LO];
  assign extendedOpcode     = pwdata[cbtc_pkg::XO_HI:cbtc_pkg::XO_LO];
  assign branchOptions      = pwdata[cbtc_pkg::BO_HI:cbtc_pkg::BO_LO];
  assign condBitIndex       = pwdata[cbtc_pkg::BI_HI:cbtc_pkg::BI_LO];
  assign reservedBits       = pwdata[cbtc_pkg::RSV_HI:cbtc_pkg::RSV_LO];
  assign branchDisplacement = pwdata[cbtc_pkg::BD_HI:cbtc_pkg::BD_LO];
  assign absoluteFlag       = pwdata[cbtc_pkg::AA_BIT];
  assign linkFlag           = pwdata[cbtc_pkg::LK_BIT];

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  logic isBcctr;
  logic isBc;
  logic noDecrement;
  logic invalidForm;
  logic unsupported;
  logic execOk;
  cbtc_pkg::cbtc_kind_e execKind;

  assign isBcctr = (primaryOpcode == cbtc_pkg::OPC_BCCTR)
                 & (extendedOpcode == cbtc_pkg::XO_BCCTR);
  assign isBc    = (primaryOpcode == cbtc_pkg::OPC_BC);
  assign noDecrement = branchOptions[cbtc_pkg::BO_NODEC];
  // Count-to-register with decrement requested is refused outright
  assign invalidForm = isBcctr & ~noDecrement;
  // Decrementing relative/absolute forms are outside this block
  assign unsupported = (isBc & ~noDecrement) | ~(isBc | isBcctr);
  assign execOk      = (isBcctr | isBc) & noDecrement;
  assign execKind    = invalidForm ? cbtc_pkg::KIND_BAD
                     : isBcctr     ? cbtc_pkg::KIND_BCCTR
                     : isBc        ? cbtc_pkg::KIND_BC
                     :               cbtc_pkg::KIND_OTHER;

  // ----------------------------------------
  // Condition test
  // ----------------------------------------
  logic       condBit;
  logic       condOk;
  logic [2:0] condFieldSelect;
  logic [1:0] condFlag;
  logic       taken;

  cbtc_cond_eval u_cond (
    .conditionRegisterBits (conditionRegisterBits_reg),
    .condBitIndex          (condBitIndex),
    .branchOptions         (branchOptions),
    .condBit               (condBit),
    .condOk                (condOk),
    .condFieldSelect       (condFieldSelect),
    .condFlag              (condFlag)
  );

  assign taken = execOk & condOk;

  // ----------------------------------------
  // Target arithmetic
  // ----------------------------------------
  logic [31:0] seqAddr;
  logic [31:0] ctrTarget;
  logic [31:0] absTarget;
  logic [31:0] relTarget;
  logic [31:0] bcTarget;
  logic [31:0] targetAddr;

  assign seqAddr   = currentInstrAddr_reg + cbtc_pkg::INSTR_BYTES;
  // Low two bits forced to zero keeps the target word aligned
  assign ctrTarget = {countReg_reg[31:2], 2'b00};
  assign absTarget = {{16{branchDisplacement[13]}}, branchDisplacement, 2'b00};
  assign relTarget = currentInstrAddr_reg + absTarget;
  assign bcTarget  = absoluteFlag ? absTarget : relTarget;
  assign targetAddr = isBcctr ? ctrTarget : bcTarget;

  // ----------------------------------------
  // Next address and link register
  // ----------------------------------------
  // Invalid form leaves every architected value as it was
  assign nextInstrAddr_next = !instrWrite ? nextInstrAddr_reg
                            : invalidForm ? nextInstrAddr_reg
                            : taken       ? targetAddr
                            :               seqAddr;

  // Hardware link update outranks a software write to the link register; software and execute never share an edge
  assign linkRegister_next = (instrWrite & execOk & linkFlag) ? seqAddr
                           : (writeDone & hitLr)              ? pwdata
                           :                                    linkRegister_reg;

  // Status is a snapshot of the latest execution
  assign status_next = instrWrite ? {3'b000,
                                     execKind,
                                     condFieldSelect,
                                     condFlag,
                                     absoluteFlag & isBc,
                                     isBcctr & (reservedBits != 5'h00),
                                     unsupported,
                                     invalidForm,
                                     execOk & linkFlag,
                                     taken}
                                  : status_reg;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [31:0] readData;
  assign readData = hitInstr ? instrWord_reg
                  : hitCia   ? currentInstrAddr_reg
                  : hitCtr   ? countReg_reg
                  : hitCr    ? conditionRegisterBits_reg
                  : hitNia   ? nextInstrAddr_reg
                  : hitLr    ? linkRegister_reg
                  : hitStat  ? {16'h0000, status_reg}
                  :            32'h0000_0000;
  assign prdata_next = (setupPhase & ~pwrite) ? readData : prdata_reg;

  // ----------------------------------------
  // Bus handshake flops
  // ----------------------------------------
  // Ready rises after setup and drops after the access edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setupPhase;
      pslverr_reg <= setupPhase & ~mapped;
      prdata_reg  <= prdata_next;
    end
  end

  // ----------------------------------------
  // Software-owned inputs
  // ----------------------------------------
  // Count register only ever changes by a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instrWord_reg             <= 32'h0000_0000;
      currentInstrAddr_reg      <= cbtc_pkg::ADDR_RST;
      countReg_reg              <= 32'h0000_0000;
      conditionRegisterBits_reg <= 32'h0000_0000;
    end else begin
      if (instrWrite) instrWord_reg <= pwdata;
      if (writeDone & hitCia) currentInstrAddr_reg <= pwdata;
      if (writeDone & hitCtr) countReg_reg <= pwdata;
      if (writeDone & hitCr) conditionRegisterBits_reg <= pwdata;
    end
  end

  // ----------------------------------------
  // Execution results
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nextInstrAddr_reg <= cbtc_pkg::ADDR_RST;
      linkRegister_reg  <= cbtc_pkg::ADDR_RST;
      status_reg        <= 16'h0000;
      branchTaken_reg   <= 1'b0;
      formInvalid_reg   <= 1'b0;
    end else begin
      nextInstrAddr_reg <= nextInstrAddr_next;
      linkRegister_reg  <= linkRegister_next;
      status_reg        <= status_next;
      branchTaken_reg   <= instrWrite & taken;
      formInvalid_reg   <= instrWrite & invalidForm;
    end
  end

  // Outputs straight from flops
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign nextInstrAddr = nextInstrAddr_reg;
  assign linkRegister  = linkRegister_reg;
  assign branchTaken   = branchTaken_reg;
  assign formInvalid   = formInvalid_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cbtcClk @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_exec_ctr;
    instrWrite && isBcctr && noDecrement;
  endsequence

  sequence s_exec_any;
    instrWrite && execOk;
  endsequence

  a_ctr_target: assert property (s_exec_ctr ##0 condOk |=> nextInstrAddr_reg == {$past(countReg_reg[31:2]), 2'b00})
    else $error("count branch target wrong");
  a_seq_fallthru: assert property (instrWrite && !taken && !invalidForm |=> nextInstrAddr_reg == $past(seqAddr))
    else $error("fall-through address wrong");
  a_link_save: assert property (s_exec_any ##0 linkFlag |=> linkRegister_reg == $past(currentInstrAddr_reg) + 32'h4)
    else $error("link register not saved");
  a_invalid_hold: assert property (instrWrite && invalidForm |=> formInvalid && $stable(nextInstrAddr_reg) && $stable(linkRegister_reg))
    else $error("invalid form changed state");
  a_true_option: assert property (s_exec_any ##0 branchOptions == cbtc_pkg::BO_IF_TRUE |=> branchTaken == $past(condBit))
    else $error("branch-if-true misjudged");
  a_false_option: assert property (s_exec_any ##0 branchOptions == cbtc_pkg::BO_IF_FALSE |=> branchTaken != $past(condBit))
    else $error("branch-if-false misjudged");
  a_abs_target: assert property (instrWrite && isBc && absoluteFlag && taken |=> nextInstrAddr_reg == $past(absTarget))
    else $error("absolute target wrong");
  a_ctr_kept: assert property (instrWrite |=> countReg_reg == $past(countReg_reg))
    else $error("count register altered");
  a_taken_pulse: assert property (instrWrite |=> branchTaken == $past(taken) ##1 !branchTaken)
    else $error("taken pulse wrong");
  a_rel_variant: assert property (instrWrite && isBc && !absoluteFlag && taken |=> nextInstrAddr_reg == $past(relTarget))
    else $error("relative target wrong");

endmodule : cbtc_branch_unit

// file: cbtc_fetch_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Instruction producer for count branches
// ----------------------------------------
module cbtc_fetch_model (
  input  wire logic [4:0]  branchOptions,
  input  wire logic [4:0]  condBitIndex,
  input  wire logic        linkFlag,
  output logic      [31:0] instrWord
);
  // Field zero stands for an omitted field operand; reserved bits stay clear
  assign instrWord = {cbtc_pkg::OPC_BCCTR, branchOptions, condBitIndex, 5'h00,
                      cbtc_pkg::XO_BCCTR, linkFlag};
endmodule : cbtc_fetch_model

// file: cond_branch_to_count_decode_tb.sv
`timescale 1ns/1ns
module cond_branch_to_count_decode_tb;
  logic        coreClk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, nextInstrAddr, linkRegister, instrWord;
  logic        pready, pslverr, branchTaken, formInvalid;
  logic [4:0]  branchOptions = 5'h14;
  logic [4:0]  condBitIndex = 5'h00;
  logic        linkFlag = 1'b0;
  logic [31:0] rdData, current_instr_addr, ctr, cr, lrExp, niaExp, tgt;
  logic        errSeen, expTaken;
  logic [13:0] disp;
  logic [4:0]  bo;
  int          nErrors = 0;
  int          nCompared = 0;
  integer      seed = 32'h7c3c;
  logic [4:0]  boTable [3] = '{5'h0c, 5'h04, 5'h14};

  // Clock, 20 ns period
  always #10 coreClk = ~coreClk;

  cbtc_branch_unit dut_u (.core_clk(coreClk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nextInstrAddr(nextInstrAddr), .linkRegister(linkRegister), .branchTaken(branchTaken),
    .formInvalid(formInvalid));
  cbtc_fetch_model fetch_u (.branchOptions(branchOptions), .condBitIndex(condBitIndex),
    .linkFlag(linkFlag), .instrWord(instrWord));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wrapUp;
    $display("compared %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrapUp

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  // One APB transfer; an idle edge first so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int i;
    @(posedge coreClk);
    paddr <= addr;
    pwrite <= wr;
    pwdata <= data;
    psel <= 1'b1;
    @(posedge coreClk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge coreClk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      nErrors++;
      wrapUp();
    end
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic condPass(input logic [4:0] opt, input logic [31:0] c, input logic [4:0] idx);
    return opt[4] | (c[5'd31 - idx] == opt[3]);
  endfunction : condPass

  // Execute a word and compare pulses and next address / link
  task automatic runBranch(input logic [31:0] instr, input logic tk, input logic inv);
    apb(1'b1, cbtc_pkg::OFS_INSTR, instr);
    #1;
    check32({31'h0, branchTaken}, {31'h0, tk});
    check32({31'h0, formInvalid}, {31'h0, inv});
    check32(nextInstrAddr, niaExp);
    check32(linkRegister, lrExp);
  endtask : runBranch

  task automatic loadRegs;
    current_instr_addr = $random(seed) & 32'hffff_fffc;
    ctr = $random(seed);
    cr = $random(seed);
    apb(1'b1, cbtc_pkg::OFS_CIA, current_instr_addr);
    apb(1'b1, cbtc_pkg::OFS_CTR, ctr);
    apb(1'b1, cbtc_pkg::OFS_CR, cr);
  endtask : loadRegs

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge coreClk);
    rst <= 1'b0;
    niaExp = 32'h0;
    lrExp = 32'h0;
    apb(1'b0, cbtc_pkg::OFS_NIA, 32'h0);
    check32(rdData, 32'h0);
    apb(1'b0, cbtc_pkg::OFS_STAT, 32'h0);
    check32(rdData, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check32({31'h0, errSeen}, 32'h1);
    check32(rdData, 32'h0);
    $display("test reset and map done");
    // Count branches over the three table options, all flags and fields
    for (int k = 0; k < 48; k++) begin
      loadRegs();
      branchOptions <= boTable[k % 3];
      condBitIndex <= {3'((k / 4) % 8), 2'(k % 4)};
      linkFlag <= 1'($random(seed));
      #1;
      expTaken = condPass(branchOptions, cr, condBitIndex);
      niaExp = expTaken ? {ctr[31:2], 2'b00} : current_instr_addr + 32'h4;
      if (linkFlag) lrExp = current_instr_addr + 32'h4;
      runBranch(instrWord, expTaken, 1'b0);
      // Snapshot: kind, field and flag split of the index, link and taken bits
      apb(1'b0, cbtc_pkg::OFS_STAT, 32'h0);
      check32(rdData, {19'h0, 2'b01, condBitIndex, 4'h0, linkFlag, expTaken});
      apb(1'b0, cbtc_pkg::OFS_CTR, 32'h0);
      check32(rdData, ctr);
    end
    $display("test count branch done");
    // Decrementing options on the count branch leave state alone
    for (int k = 0; k < 8; k++) begin
      loadRegs();
      branchOptions <= 5'($random(seed)) & 5'h1b;
      condBitIndex <= 5'($random(seed));
      linkFlag <= 1'($random(seed));
      #1;
      runBranch(instrWord, 1'b0, 1'b1);
    end
    $display("test invalid form done");
    // Conditional branch in relative, absolute and linking variants
    for (int k = 0; k < 8; k++) begin
      loadRegs();
      disp = 14'($random(seed));
      if (k < 2) disp[13] = k[0];
      bo = k[2] ? 5'h0c : 5'h04;
      tgt = {{16{disp[13]}}, disp, 2'b00};
      expTaken = condPass(bo, cr, 5'h02);
      if (expTaken) niaExp = k[1] ? tgt : current_instr_addr + tgt;
      else niaExp = current_instr_addr + 32'h4;
      if (k[0]) lrExp = current_instr_addr + 32'h4;
      runBranch({cbtc_pkg::OPC_BC, bo, 5'h02, disp, k[1], k[0]}, expTaken, 1'b0);
    end
    $display("test conditional variants done");
    apb(1'b1, cbtc_pkg::OFS_NIA, 32'h1234_5678);
    apb(1'b0, cbtc_pkg::OFS_NIA, 32'h0);
    check32(rdData, niaExp);
    $display("test read-only done");
    wrapUp();
  end
endmodule : cond_branch_to_count_decode_tb
